// file: hdl/adc_prio_pkg.sv
// constants for the top-priority conversion and result-monitor control block
// assumes a 32-bit classic wishbone master and an analog core on ref_clk
package adc_prio_pkg;

  // register byte addresses; each register's data sits in the low bits of the bus word
  localparam logic [31:0] PRIO_CTRL_IDX = 32'hFFFFF316;
  localparam logic [31:0] MON_CTRL_IDX  = 32'hFFFFF317;
  localparam logic [31:0] TRIG_CTRL_IDX = 32'hFFFFF318;
  localparam logic [31:0] MON_CMP_IDX   = 32'hFFFFF319;
  localparam logic [31:0] IRQ_STAT_IDX  = 32'hFFFFF31A;
  localparam logic [31:0] IRQ_MASK_IDX  = 32'hFFFFF31B;

  // priority_conversion_control fields
  localparam int unsigned PC_DONE_BIT  = 7;
  localparam int unsigned PC_BUSY_BIT  = 6;
  localparam int unsigned PC_START_BIT = 5;
  localparam int unsigned CHAN_W       = 5;
  localparam logic [4:0]  CHAN_MAX     = 5'h17;

  // result_monitor_control fields
  localparam int unsigned MC_SPARE_BIT = 7;
  localparam int unsigned MC_DIR_BIT   = 5;
  localparam int unsigned MC_SEL_LSB   = 1;
  localparam int unsigned MC_SEL_W     = 4;
  localparam int unsigned MC_EN_BIT    = 0;

  // trigger control fields
  localparam int unsigned TRG_SRC_BIT  = 7;
  localparam int unsigned TRG_EN_BIT   = 6;

  // interrupt status / mask layout
  localparam int unsigned IRQ_W        = 2;
  localparam int unsigned IRQ_DONE_BIT = 0;
  localparam int unsigned IRQ_MON_BIT  = 1;

  // result sizes
  localparam int unsigned RESULT_W     = 10;
  localparam int unsigned NUM_RESULTS  = 9;
  localparam int unsigned PRIO_RES_SEL = 8;

  // reset values
  localparam logic [7:0]          CTRL_RST = 8'h00;
  localparam logic [RESULT_W-1:0] CMP_RST  = 10'h000;

  function automatic logic idx_hit(input logic [31:0] adr, input logic [31:0] idx);
    idx_hit = (adr == idx);
  endfunction : idx_hit

endpackage : adc_prio_pkg

// file: hdl/adc_mon_cmp.sv
// result-monitor compare: picks one result register and compares it
// assumes result values are stable ref_clk registers of the analog core
`timescale 1ns/1ps
`default_nettype none
module adc_mon_cmp #(
  parameter int unsigned WIDTH = adc_prio_pkg::RESULT_W
) (
  // result registers, normal 0..7 then priority
  input  wire logic [WIDTH-1:0] result_value [adc_prio_pkg::NUM_RESULTS],
  // settings
  input  wire logic [3:0]       sel,
  input  wire logic             direction,
  input  wire logic             enable,
  input  wire logic [WIDTH-1:0] cmp_value,
  // compare outcome
  output logic                  hit
);
  initial begin
    if (WIDTH < 1 || WIDTH > 16) $error("adc_mon_cmp: WIDTH out of range");
  end

  logic [WIDTH-1:0] picked;

  always_comb begin
    if (sel[3]) begin
      picked = result_value[adc_prio_pkg::PRIO_RES_SEL];
    end else begin
      picked = result_value[sel[2:0]];
    end
    if (!enable) begin
      hit = 1'b0;
    end else if (direction) begin
      hit = picked > cmp_value;
    end else begin
      hit = picked < cmp_value;
    end
  end
endmodule : adc_mon_cmp
`default_nettype wire

// file: hdl/adc_irq_stat.sv
// sticky interrupt status with write-one-to-clear, mask and one level output
// assumes event pulses and write strobes on ref_clk
`timescale 1ns/1ps
`default_nettype none
module adc_irq_stat #(
  parameter int unsigned W = adc_prio_pkg::IRQ_W
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  // events and software access
  input  wire logic [W-1:0] event_set,
  input  wire logic         stat_wr,
  input  wire logic         mask_wr,
  input  wire logic [W-1:0] wr_data,
  // state
  output logic      [W-1:0] status_reg,
  output logic      [W-1:0] mask_reg,
  output logic              irq
);
  initial begin
    if (W < 1 || W > 8) $error("adc_irq_stat: W out of range");
  end

  // a new event outranks a clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_reg <= '0;
    end else begin
      status_reg <= (status_reg & ~(stat_wr ? wr_data : '0)) | event_set;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mask_reg <= '0;
    end else if (mask_wr) begin
      mask_reg <= wr_data;
    end
  end

  assign irq = |(status_reg & mask_reg);
endmodule : adc_irq_stat
`default_nettype wire

// file: hdl/adc_prio_ctrl.sv
// top-priority conversion and result-monitor control, wishbone slave
// assumes classic wishbone on ref_clk (10 MHz), analog core and timers on
// the same clock, result values held stable by the core between updates
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module adc_prio_ctrl #(
  parameter int unsigned RES_W = adc_prio_pkg::RESULT_W
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  // wishbone slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [31:0]      wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // timer match events
  input  wire logic             timer_match_0,
  input  wire logic             timer_match_1,
  // analog core
  output logic                  conv_start,
  output logic      [4:0]       conv_channel,
  input  wire logic             conv_done,
  input  wire logic [RES_W-1:0] result_value [adc_prio_pkg::NUM_RESULTS],
  // interrupt
  output logic                  irq
);
  initial begin
    if (RES_W < 1 || RES_W > 16) $error("adc_prio_ctrl: RES_W out of range");
  end

  ////////////////////////////////////////////////////////////////////////////

  logic             ack_reg;
  logic [31:0]      rdata_reg;
  logic [4:0]       chan_reg;
  logic             busy_reg;
  logic             done_reg;
  logic [7:0]       mon_ctrl_reg;
  logic [7:0]       trig_ctrl_reg;
  logic [RES_W-1:0] cmp_reg;
  logic             mon_hit_reg;
  logic             start_pulse_reg;
  logic [4:0]       conv_chan_reg;
  logic [adc_prio_pkg::IRQ_W-1:0] irq_status;
  logic [adc_prio_pkg::IRQ_W-1:0] irq_mask;
  logic [adc_prio_pkg::IRQ_W-1:0] irq_events;

  logic req;
  logic wr0;
  logic wr1;
  logic rd;
  logic hit_pc;
  logic hit_mc;
  logic hit_trg;
  logic hit_cmp;
  logic hit_ist;
  logic hit_imsk;
  logic sw_start;
  logic hw_start;
  logic start_ok;
  logic mon_hit;
  logic [31:0] rdata_next;

  // request seen once per transfer; ack drops the cycle after it is given
  assign req      = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr0      = req & wb_we_i & wb_sel_i[0];
  assign wr1      = req & wb_we_i & wb_sel_i[1];
  assign rd       = req & ~wb_we_i;
  assign hit_pc   = adc_prio_pkg::idx_hit(wb_adr_i, adc_prio_pkg::PRIO_CTRL_IDX);
  assign hit_mc   = adc_prio_pkg::idx_hit(wb_adr_i, adc_prio_pkg::MON_CTRL_IDX);
  assign hit_trg  = adc_prio_pkg::idx_hit(wb_adr_i, adc_prio_pkg::TRIG_CTRL_IDX);
  assign hit_cmp  = adc_prio_pkg::idx_hit(wb_adr_i, adc_prio_pkg::MON_CMP_IDX);
  assign hit_ist  = adc_prio_pkg::idx_hit(wb_adr_i, adc_prio_pkg::IRQ_STAT_IDX);
  assign hit_imsk = adc_prio_pkg::idx_hit(wb_adr_i, adc_prio_pkg::IRQ_MASK_IDX);

  ////////////////////////////////////////////////////////////////////////////
  // launch

  assign sw_start = wr0 & hit_pc & wb_dat_i[adc_prio_pkg::PC_START_BIT];
  assign hw_start = trig_ctrl_reg[adc_prio_pkg::TRG_EN_BIT]
                  & (trig_ctrl_reg[adc_prio_pkg::TRG_SRC_BIT] ? timer_match_1
                                                               : timer_match_0);
  // requests while busy or on an unused channel code are dropped
  assign start_ok = (sw_start | hw_start) & ~busy_reg
                  & (chan_reg <= adc_prio_pkg::CHAN_MAX);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      chan_reg <= 5'h00;
    end else if (wr0 && hit_pc) begin
      chan_reg <= wb_dat_i[adc_prio_pkg::CHAN_W-1:0];
    end
  end

  // channel is sampled in the start cycle so a launch written together with a
  // new channel code uses the old one; software writes the code first
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      start_pulse_reg <= 1'b0;
      conv_chan_reg   <= 5'h00;
    end else begin
      start_pulse_reg <= start_ok;
      if (start_ok) begin
        conv_chan_reg <= chan_reg;
      end
    end
  end

  assign conv_start   = start_pulse_reg;
  assign conv_channel = conv_chan_reg;

  ////////////////////////////////////////////////////////////////////////////
  // busy and done flags

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_reg <= 1'b0;
    end else if (start_ok) begin
      busy_reg <= 1'b1;
    end else if (conv_done) begin
      busy_reg <= 1'b0;
    end
  end

  // completion outranks the clear by a read or a new launch
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      done_reg <= 1'b0;
    end else if (conv_done && busy_reg) begin
      done_reg <= 1'b1;
    end else if (start_ok || (rd && hit_pc)) begin
      done_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // monitor

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mon_ctrl_reg <= adc_prio_pkg::CTRL_RST;
    end else if (wr0 && hit_mc) begin
      mon_ctrl_reg <= wb_dat_i[7:0] & 8'hBF;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      trig_ctrl_reg <= adc_prio_pkg::CTRL_RST;
    end else if (wr0 && hit_trg) begin
      trig_ctrl_reg <= wb_dat_i[7:0] & 8'hC0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmp_reg <= adc_prio_pkg::CMP_RST;
    end else if (hit_cmp && (wr0 || wr1)) begin
      for (int i = 0; i < RES_W; i++) begin
        if (i < 8 ? wr0 : wr1) begin
          cmp_reg[i] <= wb_dat_i[i];
        end
      end
    end
  end

  adc_mon_cmp #(
    .WIDTH        (RES_W)
  ) u_mon_cmp (
    .result_value (result_value),
    .sel          (mon_ctrl_reg[adc_prio_pkg::MC_SEL_LSB +: adc_prio_pkg::MC_SEL_W]),
    .direction    (mon_ctrl_reg[adc_prio_pkg::MC_DIR_BIT]),
    .enable       (mon_ctrl_reg[adc_prio_pkg::MC_EN_BIT]),
    .cmp_value    (cmp_reg),
    .hit          (mon_hit)
  );

  // the event is the moment the condition becomes true, not the level,
  // so a clear does not refire while the result stays past the limit
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mon_hit_reg <= 1'b0;
    end else begin
      mon_hit_reg <= mon_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts

  always_comb begin
    irq_events = '0;
    irq_events[adc_prio_pkg::IRQ_DONE_BIT] = conv_done & busy_reg;
    irq_events[adc_prio_pkg::IRQ_MON_BIT]  = mon_hit & ~mon_hit_reg;
  end

  adc_irq_stat #(
    .W          (adc_prio_pkg::IRQ_W)
  ) u_irq_stat (
    .ref_clk    (ref_clk),
    .rst_b      (rst_b),
    .event_set  (irq_events),
    .stat_wr    (wr0 & hit_ist),
    .mask_wr    (wr0 & hit_imsk),
    .wr_data    (wb_dat_i[adc_prio_pkg::IRQ_W-1:0]),
    .status_reg (irq_status),
    .mask_reg   (irq_mask),
    .irq        (irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus read and acknowledge

  always_comb begin
    rdata_next = 32'h0000_0000;
    if (hit_pc) begin
      rdata_next[adc_prio_pkg::PC_DONE_BIT] = done_reg;
      rdata_next[adc_prio_pkg::PC_BUSY_BIT] = busy_reg;
      rdata_next[adc_prio_pkg::CHAN_W-1:0]  = chan_reg;
    end else if (hit_mc) begin
      rdata_next[7:0] = mon_ctrl_reg;
    end else if (hit_trg) begin
      rdata_next[7:0] = trig_ctrl_reg;
    end else if (hit_cmp) begin
      rdata_next[RES_W-1:0] = cmp_reg;
    end else if (hit_ist) begin
      rdata_next[adc_prio_pkg::IRQ_W-1:0] = irq_status;
    end else if (hit_imsk) begin
      rdata_next[adc_prio_pkg::IRQ_W-1:0] = irq_mask;
    end
  end

  // unmapped addresses are acknowledged, read zero and ignore writes
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req;
      if (rd) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sw_launch_a: assert property (
    wr0 && hit_pc && wb_dat_i[5] && !busy_reg && (chan_reg <= 5'h17)
    |=> conv_start && busy_reg)
    else $error("software launch did not start a conversion");

  zero_write_a: assert property (
    wr0 && hit_pc && !wb_dat_i[5] && !hw_start |=> !conv_start)
    else $error("writing zero to the launch bit started a conversion");

  start_reads_zero_a: assert property (
    rd && hit_pc |=> wb_ack_o && !wb_dat_o[5])
    else $error("launch bit read back as one");

  channel_passed_a: assert property (
    start_ok |=> conv_start && conv_channel == $past(chan_reg))
    else $error("conversion channel differs from the selected code");

  bad_channel_a: assert property (
    chan_reg > 5'h17 |=> !conv_start)
    else $error("launch on an unused channel code");

  monitor_event_a: assert property (
    mon_hit && !mon_hit_reg |=> irq_status[1])
    else $error("monitor condition did not set its status bit");

  monitor_gate_a: assert property (
    !mon_ctrl_reg[0] |-> !mon_hit)
    else $error("monitor fired while disabled");

  prio_select_a: assert property (
    mon_ctrl_reg[0] && mon_ctrl_reg[4] && mon_ctrl_reg[5]
    && result_value[8] > cmp_reg |-> mon_hit)
    else $error("priority result not monitored for selector with top bit set");

  busy_done_a: assert property (
    busy_reg && conv_done && !start_ok |=> !busy_reg && done_reg)
    else $error("completion did not clear busy and set done");

  flags_ro_a: assert property (
    wr0 && hit_pc && !conv_done && !start_ok |=> $stable(busy_reg))
    else $error("software write changed the busy flag");

  hw_launch_a: assert property (
    trig_ctrl_reg[6] && !trig_ctrl_reg[7] && timer_match_0 && !busy_reg
    && (chan_reg <= 5'h17) |=> conv_start)
    else $error("timer match did not launch a conversion");

  bus_ack_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("wishbone acknowledge not one cycle after the request");

  sw_launch_c: cover property (sw_start && start_ok ##[1:50] conv_done);
  hw_launch_c: cover property (hw_start && start_ok);
  monitor_irq_c: cover property (irq_events[1] ##1 irq);
  clear_race_c: cover property (wr0 && hit_ist && |irq_events);

endmodule : adc_prio_ctrl
`default_nettype wire

// file: bench/adc_core_model.sv
// analog core stand-in: answers each start after a latency set by the bench
// assumes conv_start is a one-cycle pulse on ref_clk
`timescale 1ns/1ps
`default_nettype none
module adc_core_model (
  // clock and reset
  input  wire logic                                ref_clk,
  input  wire logic                                rst_b,
  // control from the block, latency from the bench
  input  wire logic                                conv_start,
  input  wire logic [4:0]                          conv_channel,
  input  wire logic [7:0]                          lat,
  // answers
  output logic                                     conv_done,
  output logic      [adc_prio_pkg::RESULT_W-1:0]   result_value [adc_prio_pkg::NUM_RESULTS]
);
  logic [7:0] cnt_reg;
  logic [9:0] prio_res_reg;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg      <= 8'h00;
      conv_done    <= 1'b0;
      prio_res_reg <= 10'h000;
    end else begin
      conv_done <= 1'b0;
      if (conv_start) begin
        cnt_reg <= lat;
      end else if (cnt_reg == 8'h01) begin
        cnt_reg      <= 8'h00;
        conv_done    <= 1'b1;
        prio_res_reg <= {conv_channel, 5'h00};
      end else if (cnt_reg != 8'h00) begin
        cnt_reg <= cnt_reg - 8'h01;
      end
    end
  end
  // normal results fixed so the monitor sees known values on both sides of the compare
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      result_value[i] = 10'h040 + 10'(16 * i);
    end
    result_value[8] = prio_res_reg;
  end
endmodule : adc_core_model
`default_nettype wire

// file: bench/tb_top.sv
// testbench for the priority conversion and monitor control block
// assumes the core model answers conv_start; wishbone driven here
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e, m) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("wrong value at %0t: %s", $time, m); end end
module tb_top;
  localparam logic [31:0] A_PC = adc_prio_pkg::PRIO_CTRL_IDX;
  localparam logic [31:0] A_MC = adc_prio_pkg::MON_CTRL_IDX;
  localparam logic [31:0] A_TR = adc_prio_pkg::TRIG_CTRL_IDX;
  localparam logic [31:0] A_CP = adc_prio_pkg::MON_CMP_IDX;
  localparam logic [31:0] A_ST = adc_prio_pkg::IRQ_STAT_IDX;
  localparam logic [31:0] A_MK = adc_prio_pkg::IRQ_MASK_IDX;
  logic        ref_clk, rst_b, cyc, stb, we, tm0, tm1, conv_start, conv_done, irq, ack;
  logic [31:0] adr, dat, rd, dat_o;
  logic [4:0]  conv_channel, last_chan;
  logic [7:0]  lat;
  logic [9:0]  res_v [adc_prio_pkg::NUM_RESULTS];
  logic [9:0]  res;
  logic [3:0]  s, sel, lanes;
  logic        dr, en, hit;
  int          n_fail, n_checks, n_starts, n_cyc, s0;

  adc_prio_ctrl u_adc_prio_ctrl (.ref_clk(ref_clk), .rst_b(rst_b), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .timer_match_0(tm0), .timer_match_1(tm1),
    .conv_start(conv_start), .conv_channel(conv_channel), .conv_done(conv_done),
    .result_value(res_v), .irq(irq));
  adc_core_model u_adc_core_model (.ref_clk(ref_clk), .rst_b(rst_b),
    .conv_start(conv_start), .conv_channel(conv_channel), .lat(lat),
    .conv_done(conv_done), .result_value(res_v));

  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (conv_start === 1'b1) begin
      n_starts++;
      last_chan = conv_channel;
    end
    n_cyc++;
    if (n_cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    sel <= lanes;
    adr <= a;
    dat <= d;
    // only the bench timeout ends a wait for the answer
    do begin
      @(posedge ref_clk);
    end while (ack !== 1'b1);
    q = dat_o;
    `CHK(ack, 1'b1, "no ack")
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e, input string m);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    `CHK(q, e, m)
  endtask : rd_chk
  // polling reads clear the done flag, so the last read is handed back
  task automatic wait_idle(output logic [31:0] q);
    int k;
    k = 0;
    do begin
      wb(1'b0, A_PC, 32'h0, q);
      k++;
    end while (q[6] !== 1'b0 && k < 40);
  endtask : wait_idle
  task automatic pulse(input logic which);
    @(posedge ref_clk);
    if (which) tm1 <= 1'b1;
    else tm0 <= 1'b1;
    @(posedge ref_clk);
    tm0 <= 1'b0;
    tm1 <= 1'b0;
  endtask : pulse
  task end_sim;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0; rst_b = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0;
    adr = 32'h0; dat = 32'h0; tm0 = 1'b0; tm1 = 1'b0; lat = 8'h14;
    sel = 4'hF; lanes = 4'hF;
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd_chk(A_PC, 32'h0, "prio reset");
    rd_chk(A_MC, 32'h0, "mon reset");
    `CHK(irq, 1'b0, "irq reset")
    $display("test reset done");
    // channel code written first; the launch write then repeats that same code
    wb(1'b1, A_PC, 32'h17, rd);
    rd_chk(A_PC, 32'h17, "zero start");
    `CHK(n_starts, 0, "start on zero")
    wb(1'b1, A_PC, 32'h37, rd);
    rd_chk(A_PC, 32'h57, "busy, start reads 0");
    wb(1'b1, A_PC, 32'h37, rd);
    `CHK(n_starts, 1, "start while busy")
    `CHK(last_chan, 5'h17, "channel 23")
    wait_idle(rd);
    `CHK(rd, 32'h97, "done flag")
    rd_chk(A_PC, 32'h17, "done cleared");
    rd_chk(A_ST, 32'h1, "done status");
    wb(1'b1, A_ST, 32'h1, rd);
    lat <= 8'h02;
    wb(1'b1, A_PC, 32'h00, rd);
    wb(1'b1, A_PC, 32'h20, rd);
    wait_idle(rd);
    `CHK(last_chan, 5'h00, "channel 0")
    wb(1'b1, A_PC, 32'h18, rd);
    wb(1'b1, A_PC, 32'h38, rd);
    `CHK(n_starts, 2, "channel 24 refused")
    wb(1'b1, A_PC, 32'h00, rd);
    $display("test launch done");
    wb(1'b1, A_CP, 32'h080, rd);
    wb(1'b1, A_MC, 32'hFF, rd);
    rd_chk(A_MC, 32'hBF, "mon readback");
    for (int c = 0; c < 64; c++) begin
      s  = c[5:2];
      dr = c[1];
      en = c[0];
      res = s[3] ? 10'h000 : 10'h040 + {2'h0, s, 4'h0};
      hit = en & (dr ? res > 10'h080 : res < 10'h080);
      wb(1'b1, A_MC, 32'h0, rd);
      wb(1'b1, A_ST, 32'h3, rd);
      wb(1'b1, A_MC, {26'h0, dr, s, en}, rd);
      rd_chk(A_ST, {30'h0, hit, 1'b0}, "monitor hit");
    end
    $display("test monitor done");
    wb(1'b1, A_MK, 32'h2, rd);
    wb(1'b1, A_MC, 32'h0, rd);
    wb(1'b1, A_ST, 32'h3, rd);
    wb(1'b1, A_MC, 32'h1, rd);
    // the status bit lands on the edge that ends the write
    @(posedge ref_clk);
    `CHK(irq, 1'b1, "irq raised")
    wb(1'b1, A_MK, 32'h0, rd);
    `CHK(irq, 1'b0, "irq masked")
    wb(1'b1, A_MK, 32'h2, rd);
    wb(1'b1, A_ST, 32'h2, rd);
    `CHK(irq, 1'b0, "irq cleared")
    $display("test irq done");
    s0 = n_starts;
    wb(1'b1, A_TR, 32'h40, rd);
    pulse(1'b1);
    wait_idle(rd);
    `CHK(n_starts, s0, "wrong timer source")
    pulse(1'b0);
    wait_idle(rd);
    `CHK(n_starts, s0 + 1, "timer 0 launch")
    wb(1'b1, A_TR, 32'hC0, rd);
    pulse(1'b1);
    wait_idle(rd);
    `CHK(n_starts, s0 + 2, "timer 1 launch")
    wb(1'b1, A_TR, 32'h00, rd);
    pulse(1'b0);
    wait_idle(rd);
    `CHK(n_starts, s0 + 2, "trigger disabled")
    rd_chk(A_PC + 32'h40, 32'h0, "unmapped read");
    $display("test trigger done");
    lanes = 4'h1;
    wb(1'b1, A_CP, 32'h3FF, rd);
    rd_chk(A_CP, 32'h0FF, "compare low lane only");
    lanes = 4'h2;
    wb(1'b1, A_CP, 32'h300, rd);
    rd_chk(A_CP, 32'h3FF, "compare high lane only");
    lanes = 4'h0;
    wb(1'b1, A_PC, 32'h20, rd);
    rd_chk(A_PC, 32'h00, "no launch without lane 0");
    `CHK(n_starts, s0 + 2, "launch without lane 0")
    lanes = 4'hF;
    $display("test lanes done");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
